// ### bench/fcom_bus_master.sv
// bus master model: writes the output image byte
`timescale 1ns/100ps

module fcom_bus_master (
  input wire logic clk,
  output logic out_wr,
  output logic out_addr,
  output logic [7:0] out_wdata
);
  initial begin
    out_wr = 1'b0;
    out_addr = 1'b0;
    out_wdata = 8'h00;
  end

  // --------------------------------------------------
  // one-cycle write, then gap idle cycles
  // --------------------------------------------------
  task automatic write(input logic addr, input logic [7:0] data, input int gap);
    out_wr = 1'b1;
    out_addr = addr;
    out_wdata = data;
    @(negedge clk);
    // back-to-back writes keep the strobe up
    if (gap > 0) begin
      out_wr = 1'b0;
      // released data no longer shows the last value
      out_wdata = ~data;
      repeat (gap) @(negedge clk);
    end
  endtask
endmodule // fcom_bus_master

// ### bench/test_four_channel_output_module.sv
// testbench for the four-channel output module
`timescale 1ns/100ps

module test_four_channel_output_module;
  import fcom_pkg::*;
  localparam int unsigned HALF = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic bus_ok = 1'b0;
  logic module_err = 1'b0;
  logic supply_err = 1'b0;
  logic config_err = 1'b0;
  logic out_wr;
  logic out_addr;
  logic [7:0] out_wdata;
  logic [7:0] out_rdata;
  logic [7:0] in_image;
  logic [3:0] channel_out;
  logic [3:0] channel_indicator;
  logic run_indicator;
  logic module_fault_indicator;
  int num_errors = 0;
  int n_tests = 0;
  int seed = 32'hbd5f56ae;
  logic [7:0] img = 8'h00;
  logic [7:0] d;
  logic a;
  logic r0;

  always #4 clk = ~clk;

  fcom_bus_master master (.clk(clk), .out_wr(out_wr), .out_addr(out_addr), .out_wdata(out_wdata));

  fcom_out_module #(.BLINK_HALF_CYCLES(HALF)) dut (
    .clk(clk), .rst(rst), .out_wr(out_wr), .out_addr(out_addr), .out_wdata(out_wdata),
    .out_rdata(out_rdata), .in_image(in_image), .bus_ok(bus_ok), .module_err(module_err),
    .supply_err(supply_err), .config_err(config_err), .channel_out(channel_out),
    .channel_indicator(channel_indicator), .run_indicator(run_indicator),
    .module_fault_indicator(module_fault_indicator)
  );

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    if (num_errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #100000;
    num_errors++;
    print_verdict();
  end

  // --------------------------------------------------
  // main sequence
  // --------------------------------------------------
  initial begin
    repeat (12) @(negedge clk);
    check({channel_out, channel_indicator}, 8'h00);
    check({6'h00, run_indicator, module_fault_indicator}, 8'h00);
    rst = 1'b0;
    for (int i = 0; i < 60; i++) begin
      {bus_ok, module_err, supply_err, config_err} = 4'($random(seed));
      a = 1'($random(seed));
      d = 8'($random(seed));
      if (!a)
        img = d;
      master.write(a, d, i % 3);
      check({4'h0, channel_out}, {4'h0, img[3:0]});
      check({4'h0, channel_indicator}, {4'h0, img[3:0]});
      check(out_rdata, a ? 8'h00 : img);
      check(in_image, 8'h00);
      if (supply_err)
        check({6'h00, run_indicator, module_fault_indicator}, 8'h00);
      else if (config_err)
        check({7'h00, run_indicator}, {7'h00, module_fault_indicator});
      else if (!bus_ok)
        check({6'h00, run_indicator, module_fault_indicator}, 8'h01);
      else
        check({6'h00, run_indicator, module_fault_indicator}, {6'h00, 1'b1, module_err});
    end
    supply_err = 1'b0;
    config_err = 1'b1;
    repeat (2) @(negedge clk);
    r0 = run_indicator;
    repeat (HALF) @(negedge clk);
    check({7'h00, run_indicator}, {7'h00, ~r0});
    check({7'h00, module_fault_indicator}, {7'h00, ~r0});
    rst = 1'b1;
    @(negedge clk);
    check({channel_out, channel_indicator}, 8'h00);
    check(out_rdata, 8'h00);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    check({channel_out, channel_indicator}, 8'h00);
    check(out_rdata, 8'h00);
    print_verdict();
  end
endmodule // test_four_channel_output_module

// ### rtl/fcom_blinker.sv
// free-running square wave for blinking indicators
`timescale 1ns/100ps
`include "fcom_defines.svh"

module fcom_blinker #(
  parameter int unsigned HALF_CYCLES = `FCOM_BLINK_HALF_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  output logic blink
);
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic blink_reg;
  logic blink_next;

  always_comb begin
    cnt_next = cnt_reg + 32'h1;
    blink_next = blink_reg;
    if (cnt_reg >= HALF_CYCLES - 1) begin
      cnt_next = 32'h0;
      blink_next = ~blink_reg;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 32'h0;
      blink_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      blink_reg <= blink_next;
    end
  end

  assign blink = blink_reg;
endmodule // fcom_blinker

// ### rtl/fcom_defines.svh
// constants for the four-channel output module
`ifndef FCOM_DEFINES_SVH
`define FCOM_DEFINES_SVH

`define FCOM_OUT_IMAGE_OFFSET 1'h0
`define FCOM_OUT_IMAGE_RESET 8'h00
`define FCOM_CH_LSB 0
`define FCOM_CH_MSB 3
`define FCOM_NUM_CH 4
`define FCOM_CLK_HZ 125000000
`define FCOM_BLINK_HZ 2
// half period of the blink, in clock cycles
`define FCOM_BLINK_HALF_CYCLES (`FCOM_CLK_HZ / (2 * `FCOM_BLINK_HZ))

`endif

// ### rtl/fcom_out_module.sv
// four-channel output module: output image, channel drive and indicators
//
// Summary of operation
// - byte at offset zero, low nibble drives channels
// - input image reads as nothing, always zero
// - channel indicator follows its channel output
// - healthy bus and module: run on, fault off
// - bus ok, module error: both lit
// - bus lost, module error: fault only
// - supply error: run and fault dark
// - configuration error: both blink at 2 Hz
`timescale 1ns/100ps
`include "fcom_defines.svh"

module fcom_out_module
  import fcom_pkg::*;
#(
  parameter int unsigned BLINK_HALF_CYCLES = `FCOM_BLINK_HALF_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic out_wr,
  input wire logic out_addr,
  input wire logic [7:0] out_wdata,
  output logic [7:0] out_rdata,
  output logic [7:0] in_image,
  input wire logic bus_ok,
  input wire logic module_err,
  input wire logic supply_err,
  input wire logic config_err,
  output logic [3:0] channel_out,
  output logic [3:0] channel_indicator,
  output logic run_indicator,
  output logic module_fault_indicator
);

  // ------------------------------------------------------------
  // output image
  // ------------------------------------------------------------
  fcom_byte_t output_image_byte_reg;
  fcom_byte_t output_image_byte_next;
  logic [3:0] ch_reg;
  logic [3:0] ch_next;
  logic [3:0] chind_reg;
  logic [3:0] chind_next;

  always_comb begin
    output_image_byte_next = output_image_byte_reg;
    if (out_wr && out_addr == `FCOM_OUT_IMAGE_OFFSET) begin
      output_image_byte_next = out_wdata;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `FCOM_NUM_CH; gi++) begin : g_ch
      // reserved upper bits have no effect
      assign ch_next[gi] = output_image_byte_next[`FCOM_CH_LSB + gi];
      assign chind_next[gi] = output_image_byte_next[`FCOM_CH_LSB + gi];
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      output_image_byte_reg <= `FCOM_OUT_IMAGE_RESET;
      ch_reg <= 4'h0;
      chind_reg <= 4'h0;
    end else begin
      output_image_byte_reg <= output_image_byte_next;
      ch_reg <= ch_next;
      chind_reg <= chind_next;
    end
  end

  // ------------------------------------------------------------
  // read-back and input image
  // ------------------------------------------------------------
  fcom_byte_t rdata_reg;
  fcom_byte_t rdata_next;
  fcom_byte_t inimg_reg;

  always_comb begin
    rdata_next = 8'h00;
    if (out_addr == `FCOM_OUT_IMAGE_OFFSET) begin
      rdata_next = output_image_byte_next;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= 8'h00;
      inimg_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
      inimg_reg <= 8'h00;
    end
  end

  // ------------------------------------------------------------
  // status indicators
  // ------------------------------------------------------------
  logic blink;
  fcom_status_e status;
  logic run_reg;
  logic run_next;
  logic fault_reg;
  logic fault_next;

  fcom_blinker #(
    .HALF_CYCLES(BLINK_HALF_CYCLES)
  ) u_blinker (
    .clk(clk),
    .rst(rst),
    .blink(blink)
  );

  always_comb begin
    if (supply_err) begin
      status = FCOM_ST_SUPPLY_ERR;
    end else if (!bus_ok) begin
      status = FCOM_ST_NO_BUS;
    end else if (module_err) begin
      status = FCOM_ST_MOD_ERR;
    end else begin
      status = FCOM_ST_OK;
    end
  end

  always_comb begin
    run_next = 1'b0;
    fault_next = 1'b0;
    if (config_err && !supply_err) begin
      run_next = blink;
      fault_next = blink;
    end else begin
      case (status)
        FCOM_ST_OK: begin
          run_next = 1'b1;
          fault_next = 1'b0;
        end
        FCOM_ST_MOD_ERR: begin
          run_next = 1'b1;
          fault_next = 1'b1;
        end
        FCOM_ST_NO_BUS: begin
          // lost bus with no module error shows fault too, run stays dark
          run_next = 1'b0;
          fault_next = 1'b1;
        end
        FCOM_ST_SUPPLY_ERR: begin
          run_next = 1'b0;
          fault_next = 1'b0;
        end
        default: begin
          run_next = 1'b0;
          fault_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_reg <= 1'b0;
      fault_reg <= 1'b0;
    end else begin
      run_reg <= run_next;
      fault_reg <= fault_next;
    end
  end

  assign out_rdata = rdata_reg;
  assign in_image = inimg_reg;
  assign channel_out = ch_reg;
  assign channel_indicator = chind_reg;
  assign run_indicator = run_reg;
  assign module_fault_indicator = fault_reg;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  property p_write_drives;
    @(posedge clk) disable iff (rst)
      (out_wr && out_addr == 1'b0) |=> (channel_out == $past(out_wdata[3:0]));
  endproperty
  a_write_drives: assert property (p_write_drives) else $error("channel outputs miss write");

  property p_hold;
    @(posedge clk) disable iff (rst)
      !(out_wr && out_addr == 1'b0) |=> $stable(channel_out);
  endproperty
  a_hold: assert property (p_hold) else $error("channel outputs changed without write");

  property p_no_input;
    @(posedge clk) disable iff (rst)
      1'b1 |=> (in_image == 8'h00);
  endproperty
  a_no_input: assert property (p_no_input) else $error("input image not empty");

  property p_ind_follow;
    @(posedge clk) disable iff (rst)
      channel_indicator == channel_out;
  endproperty
  a_ind_follow: assert property (p_ind_follow) else $error("channel indicator mismatch");

  property p_ok;
    @(posedge clk) disable iff (rst)
      (bus_ok && !module_err && !supply_err && !config_err) |=> (run_indicator && !module_fault_indicator);
  endproperty
  a_ok: assert property (p_ok) else $error("healthy indication wrong");

  property p_mod_err;
    @(posedge clk) disable iff (rst)
      (bus_ok && module_err && !supply_err && !config_err) |=> (run_indicator && module_fault_indicator);
  endproperty
  a_mod_err: assert property (p_mod_err) else $error("module error indication wrong");

  property p_no_bus;
    @(posedge clk) disable iff (rst)
      (!bus_ok && module_err && !supply_err && !config_err) |=> (!run_indicator && module_fault_indicator);
  endproperty
  a_no_bus: assert property (p_no_bus) else $error("bus loss indication wrong");

  property p_supply;
    @(posedge clk) disable iff (rst)
      supply_err |=> (!run_indicator && !module_fault_indicator);
  endproperty
  a_supply: assert property (p_supply) else $error("supply error indication wrong");

  property p_blink;
    @(posedge clk) disable iff (rst)
      (config_err && !supply_err) |=> (run_indicator == module_fault_indicator);
  endproperty
  a_blink: assert property (p_blink) else $error("blink indicators not in step");

  // cycles the run indicator has stood unchanged while blinking
  logic [31:0] steady_reg;
  logic [31:0] steady_next;

  always_comb begin
    steady_next = 32'h0;
    if (config_err && !supply_err && run_next == run_reg) begin
      steady_next = steady_reg + 32'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      steady_reg <= 32'h0;
    end else begin
      steady_reg <= steady_next;
    end
  end

  property p_blink_rate;
    @(posedge clk) disable iff (rst)
      steady_reg <= BLINK_HALF_CYCLES;
  endproperty
  a_blink_rate: assert property (p_blink_rate) else $error("blink indicators stopped toggling");

  property p_reset_zero;
    @(posedge clk)
      $fell(rst) |-> (channel_out == 4'h0);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("outputs not zero after reset");

endmodule // fcom_out_module

// ### rtl/fcom_pkg.sv
// types for the four-channel output module
package fcom_pkg;
  typedef enum logic [1:0] {
    FCOM_ST_OK,
    FCOM_ST_MOD_ERR,
    FCOM_ST_NO_BUS,
    FCOM_ST_SUPPLY_ERR
  } fcom_status_e;
  typedef logic [7:0] fcom_byte_t;
endpackage
